// ### design/vbr_pkg.sv
// Shared constants, states and field layouts of the backplane requester.
package vbr_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int TO_US      = 128;                 // Request time-out, microseconds
    localparam int CLK_MHZ    = 100;                 // Local clock rate
    localparam int TO_CYC_DEF = TO_US * CLK_MHZ;     // Time-out in clock cycles
    localparam logic [1:0] SETTLE_CYC = 2'h3;        // Own BR echo leaving the synchroniser

    // ------------------------------------------------------------
    // Arbitration levels and synchroniser vector layout
    // ------------------------------------------------------------
    localparam int NUM_LVL  = 4;                     // Bus request / grant levels
    localparam int SY_BG    = 0;                     // Grant inputs, four bits
    localparam int SY_BR    = 4;                     // Request lines, four bits
    localparam int SY_BCLR  = 8;                     // Bus clear
    localparam int SY_AS    = 9;                     // Address strobe
    localparam int SY_DTACK = 10;                    // Transfer acknowledge
    localparam int SY_BERR  = 11;                    // Bus error
    localparam int SYNC_W   = 12;                    // Width of the vector

    // ------------------------------------------------------------
    // Widths of the master data path
    // ------------------------------------------------------------
    localparam int ADDR_W = 23;                      // Word address lines 1..23
    localparam int DATA_W = 16;                      // Data path
    localparam int AM_W   = 6;                       // Address modifier lines
    localparam logic [AM_W-1:0] AM_DRIVEN = 6'h17;   // Only AM0..AM2 and AM4 driven

    // ------------------------------------------------------------
    // Requester states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,                          // No request, no mastership
        ST_PASS    = 6'h02,                          // Passing a grant down the chain
        ST_REQ     = 6'h04,                          // Request asserted, awaiting grant
        ST_WAIT_AS = 6'h08,                          // Granted, old master finishing
        ST_MASTER  = 6'h10,                          // Holding the bus
        ST_RELEASE = 6'h20                           // Finishing cycle before release
    } vbr_st_e;

    // ------------------------------------------------------------
    // Transfer engine phases, one-hot
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CY_IDLE = 4'h1,                              // No transfer
        CY_ADDR = 4'h2,                              // Address set up, strobe high
        CY_STRB = 4'h4,                              // Strobes low, awaiting answer
        CY_DONE = 4'h8                               // Answer given, awaiting negation
    } vbr_cyc_e;

endpackage

// ### design/vbr_requester.sv
// Backplane bus requester: request, acquire, release, grant pass-on, master cycles.
`timescale 1ns/100ps
// Notes on behaviour
// R1: strobe when processor starts off-board or vector cycle
// R2: strobe while not master asserts own-level request
// R3: processor waits until granted and acknowledged
// R4: enabled time-out aborts cycle after 128 us
// R5: block-transfer bit requests and keeps mastership
// R6: request held until own grant, inputs ignored
// R7: grant with own request pending takes mastership
// R8: after AS high: drop request, busy, drivers on
// R9: status flag shows bus available to board
// R10: block-transfer bit set means never release
// R11: bus clear in block mode raises maskable interrupt
// R12: setting bit while master changes nothing
// R13: without bit, keep bus until foreign request
// R14: release after cycle ends: drivers off, busy off
// R15: no request pending passes grant while input low
// R16: other three levels pass straight through
// R17: write line high for reads, low for writes
// R18: AS fall marks address; rise ends old cycle
// R19: low strobe low byte, high strobe high byte
// R20: 23-bit word address, 16-bit data path
// R21: drive AM0-AM2, AM4 only; others undriven
// R22: arbiter asserts bus clear on higher request
// R23: backplane arbitration inputs are synchronised
// R24: reset leaves requester idle, bit cleared
module vbr_requester #(
    parameter int TIMEOUT_CYC = vbr_pkg::TO_CYC_DEF  // Time-out length in cycles
) (
    input  wire logic                        clk,
    input  wire logic                        arst_n,
    input  wire logic [1:0]                  level_sel,
    input  wire logic                        timeout_en,
    input  wire logic                        bclr_irq_en,
    input  wire logic                        bbt_wr,
    input  wire logic                        bbt_wdata,
    output logic                             block_transfer_request_bit,
    output logic                             backplane_available_flag,
    output logic                             bclr_irq,
    input  wire logic                        cpu_req,
    input  wire logic                        cpu_offboard,
    input  wire logic                        cpu_iack,
    input  wire logic                        cpu_write,
    input  wire logic [1:0]                  cpu_be,
    input  wire logic [vbr_pkg::ADDR_W-1:0]  cpu_addr,
    input  wire logic [3:0]                  cpu_am,
    input  wire logic [vbr_pkg::DATA_W-1:0]  cpu_wdata,
    output logic                             offboard_request_strobe,
    output logic                             cpu_wait,
    output logic                             cpu_ack,
    output logic                             cpu_berr,
    output logic                             cpu_abort,
    output logic [vbr_pkg::DATA_W-1:0]       cpu_rdata,
    input  wire logic [3:0]                  br_i,
    output logic [3:0]                       br_o,
    output logic [3:0]                       br_oe,
    input  wire logic [3:0]                  bg_in_n,
    output logic [3:0]                       bg_out_n,
    output logic                             bbsy_o,
    output logic                             bbsy_oe,
    input  wire logic                        bclr_n,
    input  wire logic                        as_i,
    output logic                             as_o,
    output logic                             as_oe,
    input  wire logic                        dtack_n,
    input  wire logic                        berr_n,
    output logic                             drv_en,
    output logic [vbr_pkg::ADDR_W-1:0]       addr_o,
    output logic [vbr_pkg::AM_W-1:0]         am_o,
    output logic [vbr_pkg::AM_W-1:0]         am_oe,
    output logic                             write_n,
    output logic                             ds0_n,
    output logic                             ds1_n,
    input  wire logic [vbr_pkg::DATA_W-1:0]  d_i,
    output logic [vbr_pkg::DATA_W-1:0]       d_o,
    output logic                             d_oe
);
    import vbr_pkg::*;

    localparam int TO_W = $clog2(TIMEOUT_CYC + 1);                // Time-out counter width
    localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CYC - 1); // Final count

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        logic [SYNC_W-1:0] s1;          // Synchroniser first stage
        logic [SYNC_W-1:0] s2;          // Synchroniser second stage
        vbr_st_e           st;          // Requester state
        vbr_cyc_e          cyc;         // Transfer phase
        logic              bbt;         // Block-transfer request bit
        logic [1:0]        settle;      // Blanking of own request echo
        logic [TO_W-1:0]   to_cnt;      // Time-out counter
        logic              ack;         // Acknowledge pulse to processor
        logic              berr;        // Bus error pulse to processor
        logic              abort;       // Time-out pulse to processor
        logic              irq;         // Bus clear interrupt request
        logic [ADDR_W-1:0] addr;        // Latched address
        logic [3:0]        am;          // Latched modifier (AM0..2, AM4)
        logic              wr;          // Latched direction
        logic [1:0]        be;          // Latched byte lanes
        logic [DATA_W-1:0] wdata;       // Latched write data
        logic [DATA_W-1:0] rdata;       // Captured read data
    } vbr_state_s;

    vbr_state_s state_reg;              // Registered state
    vbr_state_s state_next;             // Next state

    logic [3:0] own_mask;               // One-hot of the jumpered level
    logic [3:0] bg_s;                   // Synchronised grant inputs
    logic [3:0] br_s;                   // Synchronised request lines
    logic       grant;                  // Grant low on own level
    logic       foreign;                // Another module requests
    logic       want;                   // Something needs the bus
    logic       rel_now;                // Release condition in master

    // ------------------------------------------------------------
    // Decoding of the synchronised inputs
    // ------------------------------------------------------------
    always_comb begin
        own_mask                = 4'h1 << level_sel;
        bg_s                    = state_reg.s2[SY_BG +: NUM_LVL];
        br_s                    = state_reg.s2[SY_BR +: NUM_LVL];
        grant                   = ~bg_s[level_sel];
        // Own request line is still seen low for a few cycles after negation
        foreign                 = (|(~br_s)) && (state_reg.settle == 2'h0);        // see R13
        offboard_request_strobe = cpu_req & (cpu_offboard | cpu_iack);             // see R1
        want                    = offboard_request_strobe | state_reg.bbt;        // see R5
        rel_now                 = ~state_reg.bbt & foreign;                        // see R10
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_next       = state_reg;
        // Backplane lines are asynchronous to clk
        state_next.s1    = {~berr_n, ~dtack_n, as_i, bclr_n, br_i, bg_in_n};     // see R23
        state_next.s1[SY_BERR]  = berr_n;
        state_next.s1[SY_DTACK] = dtack_n;
        state_next.s2    = state_reg.s1;                                           // see R23
        state_next.ack   = 1'b0;
        state_next.berr  = 1'b0;
        state_next.abort = 1'b0;

        // Software may write the bit at any time; state is not disturbed
        if (bbt_wr) begin
            state_next.bbt = bbt_wdata;                                            // see R12
        end
        if (state_reg.settle != 2'h0) begin
            state_next.settle = state_reg.settle - 2'h1;
        end

        // Requester sequence
        case (state_reg.st)
            ST_IDLE: begin
                if (grant) begin
                    state_next.st = ST_PASS;                                       // see R15
                end else if (want) begin
                    state_next.st = ST_REQ;                                        // see R2
                end
            end
            ST_PASS: begin
                if (!grant) begin
                    state_next.st = ST_IDLE;                                       // see R15
                end
            end
            ST_REQ: begin
                // Strobe and bit changes are ignored until the grant
                if (grant) begin
                    state_next.st = ST_WAIT_AS;                                    // see R6, R7
                end
            end
            ST_WAIT_AS: begin
                // Rising AS is the end of the previous master's last cycle
                if (state_reg.s2[SY_AS]) begin
                    state_next.st     = ST_MASTER;                                 // see R8
                    state_next.settle = SETTLE_CYC;
                end
            end
            ST_MASTER: begin
                if (rel_now) begin
                    state_next.st = (state_reg.cyc == CY_IDLE) ? ST_IDLE : ST_RELEASE; // see R14
                end
            end
            ST_RELEASE: begin
                if (state_reg.cyc == CY_IDLE) begin
                    state_next.st = ST_IDLE;                                       // see R14
                end
            end
            default: begin
                state_next.st = ST_IDLE;
            end
        endcase

        // Master transfer engine
        case (state_reg.cyc)
            CY_IDLE: begin
                if (state_reg.st == ST_MASTER && offboard_request_strobe && !rel_now) begin
                    state_next.cyc   = CY_ADDR;
                    state_next.addr  = cpu_addr;                                   // see R20
                    state_next.am    = cpu_am;
                    state_next.wr    = cpu_write;
                    state_next.be    = cpu_be;
                    state_next.wdata = cpu_wdata;
                end
            end
            CY_ADDR: begin
                // Address stands one cycle before AS falls
                state_next.cyc = CY_STRB;                                          // see R18
            end
            CY_STRB: begin
                if (!state_reg.s2[SY_DTACK] || !state_reg.s2[SY_BERR]) begin
                    state_next.cyc   = CY_DONE;
                    state_next.rdata = d_i;
                    state_next.ack   = ~state_reg.s2[SY_DTACK];                    // see R3
                    state_next.berr  = state_reg.s2[SY_DTACK];
                end
            end
            CY_DONE: begin
                if (!cpu_req && state_reg.s2[SY_DTACK] && state_reg.s2[SY_BERR]) begin
                    state_next.cyc = CY_IDLE;
                end
            end
            default: begin
                state_next.cyc = CY_IDLE;
            end
        endcase

        // Time-out watch over a waiting processor cycle
        if (timeout_en && offboard_request_strobe && state_reg.cyc != CY_DONE
                && !state_reg.ack && !state_reg.berr && !state_reg.abort) begin
            if (state_reg.to_cnt == TO_LAST) begin
                state_next.abort  = 1'b1;                                          // see R4
                state_next.to_cnt = '0;
                if (state_reg.cyc != CY_IDLE) begin
                    state_next.cyc = CY_DONE;
                end
            end else begin
                state_next.to_cnt = state_reg.to_cnt + TO_W'(1);                   // see R4
            end
        end else begin
            state_next.to_cnt = '0;
        end

        // Bus clear only interrupts a block-transfer master
        state_next.irq = bclr_irq_en && state_reg.st == ST_MASTER
                         && state_reg.bbt && !state_reg.s2[SY_BCLR];               // see R11
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg        <= '0;                                                // see R24
            state_reg.s1     <= {SYNC_W{1'b1}};
            state_reg.s2     <= {SYNC_W{1'b1}};
            state_reg.st     <= ST_IDLE;
            state_reg.cyc    <= CY_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Grant daisy chain
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_LVL; g = g + 1) begin : gen_grant
            // Foreign levels are wires; own level only while passing
            assign bg_out_n[g] = own_mask[g] ? (state_reg.st != ST_PASS)          // see R15
                                             : bg_in_n[g];                         // see R16
        end
    endgenerate

    // ------------------------------------------------------------
    // Backplane and processor outputs
    // ------------------------------------------------------------
    always_comb begin
        br_o     = 4'h0;
        br_oe    = (state_reg.st == ST_REQ || state_reg.st == ST_WAIT_AS)
                   ? own_mask : 4'h0;                                              // see R2
        drv_en   = (state_reg.st == ST_MASTER || state_reg.st == ST_RELEASE);      // see R8
        bbsy_o   = 1'b0;
        bbsy_oe  = drv_en;                                                         // see R8
        backplane_available_flag   = (state_reg.st == ST_MASTER);                  // see R9
        block_transfer_request_bit = state_reg.bbt;
        bclr_irq = state_reg.irq;
        as_oe    = drv_en;
        as_o     = (state_reg.cyc != CY_STRB);                                     // see R18
        addr_o   = state_reg.addr;                                                 // see R20
        am_o     = {1'b0, state_reg.am[3], 1'b0, state_reg.am[2:0]};               // see R21
        am_oe    = drv_en ? AM_DRIVEN : 6'h00;                                     // see R21
        write_n  = ~state_reg.wr;                                                  // see R17
        ds0_n    = ~(state_reg.cyc == CY_STRB && state_reg.be[0]);                 // see R19
        ds1_n    = ~(state_reg.cyc == CY_STRB && state_reg.be[1]);                 // see R19
        d_o      = state_reg.wdata;
        d_oe     = drv_en && state_reg.wr
                   && (state_reg.cyc == CY_ADDR || state_reg.cyc == CY_STRB);      // see R20
        cpu_ack   = state_reg.ack;
        cpu_berr  = state_reg.berr;
        cpu_abort = state_reg.abort;
        cpu_rdata = state_reg.rdata;
        cpu_wait  = offboard_request_strobe
                    & ~(state_reg.ack | state_reg.berr | state_reg.abort);         // see R3
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking dc @(posedge clk); endclocking
    default disable iff (!arst_n);

    req_raise_a: assert property (state_reg.st == ST_IDLE && !grant && want      // see R2
        |=> ((br_oe & own_mask) != 4'h0)) else $error("request not raised");
    req_hold_a: assert property (state_reg.st == ST_REQ && !grant                // see R6
        |=> state_reg.st == ST_REQ && br_oe == own_mask) else $error("request dropped");
    acquire_a: assert property (state_reg.st == ST_WAIT_AS && state_reg.s2[SY_AS] // see R8
        |=> bbsy_oe && br_oe == 4'h0 && drv_en) else $error("acquire sequence wrong");
    bbt_keep_a: assert property (state_reg.st == ST_MASTER && state_reg.bbt      // see R10
        |=> bbsy_oe) else $error("bus released in block mode");
    release_a: assert property (state_reg.st == ST_MASTER && rel_now             // see R14
        && state_reg.cyc == CY_IDLE |=> !bbsy_oe && !drv_en) else $error("no release");
    grant_pass_a: assert property (state_reg.st == ST_PASS                       // see R15
        |-> bg_out_n == (bg_in_n & ~own_mask)) else $error("grant not passed");
    timeout_a: assert property ($rose(cpu_abort)                                 // see R4
        |-> timeout_en && $past(state_reg.to_cnt) == TO_LAST) else $error("bad abort");
    wait_a: assert property (offboard_request_strobe && !cpu_ack && !cpu_berr    // see R3
        && !cpu_abort |-> cpu_wait) else $error("processor not held");
    am_drive_a: assert property (!am_oe[3] && !am_oe[5])                        // see R21
        else $error("undriven modifier driven");
    strobe_a: assert property (state_reg.cyc == CY_ADDR                         // see R19
        |=> !as_o && ds0_n == !state_reg.be[0] && ds1_n == !state_reg.be[1])
        else $error("strobes wrong");
    irq_a: assert property (state_reg.st == ST_MASTER && state_reg.bbt          // see R11
        && bclr_irq_en && !state_reg.s2[SY_BCLR] |=> bclr_irq) else $error("no irq");
    sync_lag_a: assert property ($fell(state_reg.s2[SY_AS])                     // see R23
        |-> $past(as_i, 2) == 1'b0) else $error("sync depth wrong");

endmodule

// ### tb/vbr_arb_model.sv
// Behavioural backplane arbiter, foreign masters and a prompt slave.
`timescale 1ns/100ps
module vbr_arb_model (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [3:0] br_oe,
    input  wire logic [3:0] ext_req,
    input  wire logic       bbsy_oe,
    input  wire logic       as_o,
    input  wire logic       as_oe,
    input  wire logic       ds0_n,
    input  wire logic       ds1_n,
    input  wire logic       clr_req,
    output logic      [3:0] br_i,
    output logic      [3:0] bg_in_n,
    output logic            as_i,
    output logic            dtack_n,
    output logic            bclr_n
);
    // ----------------------------------------
    // Wired lines, pull-ups where released
    // ----------------------------------------
    assign br_i   = ~(br_oe | ext_req);        // Open-collector request lines
    assign as_i   = as_oe ? as_o : 1'b1;       // Released strobe floats high
    assign bclr_n = ~clr_req;                  // Higher level pending
    // Grant highest requested level while bus free; drop once busy or unrequested
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bg_in_n <= 4'hf;
            dtack_n <= 1'b1;
        end else begin
            dtack_n <= ds0_n & ds1_n;          // Slave answers one cycle after strobes
            if (bg_in_n != 4'hf) begin
                if (bbsy_oe || (br_i | bg_in_n) == 4'hf) bg_in_n <= 4'hf;
            end else if (!bbsy_oe) begin
                casez (br_i)
                    4'b0???: bg_in_n <= 4'h7;
                    4'b10??: bg_in_n <= 4'hb;
                    4'b110?: bg_in_n <= 4'hd;
                    4'b1110: bg_in_n <= 4'he;
                    default: bg_in_n <= 4'hf;
                endcase
            end
        end
    end
endmodule

// ### tb/vbr_requester_tb.sv
// Self-checking bench of the backplane requester.
`timescale 1ns/100ps
`define CHK(nm,e,g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("FAIL %s exp %0h got %0h", nm, e, g); end end
`define WAITC(c) begin guard = 0; while (!(c) && guard < 200) begin @(posedge clk); #1; \
    guard++; end if (guard >= 200) begin err_total++; finish_test(); end end
module vbr_requester_tb;
    import vbr_pkg::*;
    int   err_total = 0, samples_checked = 0, guard;
    logic clk = 0, arst_n = 0, timeout_en = 0, bclr_irq_en = 0, bbt_wr = 0, bbt_wdata = 0;
    logic cpu_req = 0, cpu_offboard = 0, cpu_iack = 0, cpu_write = 0, clr_req = 0;
    logic berr_n = 1, bclr_n, as_i, dtack_n, bbsy_o, bbsy_oe, as_o, as_oe, drv_en, d_oe;
    logic block_transfer_request_bit, backplane_available_flag, bclr_irq, cpu_wait;
    logic offboard_request_strobe, cpu_ack, cpu_berr, cpu_abort, write_n, ds0_n, ds1_n;
    logic [1:0] level_sel = 2'h2, cpu_be = 2'h3;
    logic [3:0] cpu_am = 4'h5, ext_req = 4'h0, br_i, bg_in_n, br_o, br_oe, bg_out_n;
    logic [ADDR_W-1:0] cpu_addr = 23'h0, addr_o;
    logic [DATA_W-1:0] cpu_wdata = 16'h0, d_i = 16'h5a3c, cpu_rdata, d_o;
    logic [AM_W-1:0] am_o, am_oe;
    vbr_requester #(.TIMEOUT_CYC(40)) i_dut (.clk, .arst_n, .level_sel, .timeout_en,
        .bclr_irq_en, .bbt_wr, .bbt_wdata, .block_transfer_request_bit,
        .backplane_available_flag, .bclr_irq, .cpu_req, .cpu_offboard, .cpu_iack, .cpu_write,
        .cpu_be, .cpu_addr, .cpu_am, .cpu_wdata, .offboard_request_strobe, .cpu_wait,
        .cpu_ack, .cpu_berr, .cpu_abort, .cpu_rdata, .br_i, .br_o, .br_oe, .bg_in_n,
        .bg_out_n, .bbsy_o, .bbsy_oe, .bclr_n, .as_i, .as_o, .as_oe, .dtack_n, .berr_n,
        .drv_en, .addr_o, .am_o, .am_oe, .write_n, .ds0_n, .ds1_n, .d_i, .d_o, .d_oe);
    vbr_arb_model i_arb (.clk, .arst_n, .br_oe, .ext_req, .bbsy_oe, .as_o, .as_oe, .ds0_n,
        .ds1_n, .clr_req, .br_i, .bg_in_n, .as_i, .dtack_n, .bclr_n);
    always #5 clk = ~clk;
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One processor cycle to the backplane, acquiring the bus first if needed
    task automatic cyc(input logic wr, input logic [1:0] be, input logic [22:0] a,
                       input logic [15:0] wd);
        {cpu_write, cpu_be, cpu_addr, cpu_wdata} = {wr, be, a, wd};
        cpu_offboard = 1;
        cpu_req = 1;
        // Let the decoder settle before looking at its strobe
        #1;
        `CHK("strobe", 1'b1, offboard_request_strobe)
        if (!backplane_available_flag) begin
            `WAITC(br_oe != 4'h0)
            `CHK("br_oe", 4'h4, br_oe)
        end
        `WAITC(!ds0_n || !ds1_n)
        `CHK("ds", ~be, {ds1_n, ds0_n})
        `CHK("write_n", ~wr, write_n)
        `CHK("am_oe", 6'h17, am_oe)
        `CHK("bus", {6'h05, 1'b0, wr}, {am_o, as_o, d_oe})
        `CHK("addr", a, addr_o)
        `CHK("mastered", 6'h30, {backplane_available_flag, bbsy_oe, br_oe})
        `CHK("wait", 1'b1, cpu_wait)
        if (wr) `CHK("d_o", wd, d_o)
        `WAITC(cpu_ack)
        if (!wr) `CHK("rdata", 16'h5a3c, cpu_rdata)
        cpu_req = 0;
        // Transfer phase clears only once the answer is seen gone
        tick(4);
    endtask
    task automatic set_bit(input logic v);
        {bbt_wr, bbt_wdata} = {1'b1, v};
        tick(1);
        bbt_wr = 0;
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        tick(6);
        arst_n = 1;
        `CHK("reset", 7'h0, {br_oe, bbsy_oe, drv_en, block_transfer_request_bit})
        `CHK("idle", 14'h0ff, {br_o, bbsy_o, cpu_berr, as_o, ds1_n, ds0_n, write_n, bg_out_n})
        cyc(1'b0, 2'h3, 23'h123456, 16'h0);
        cyc(1'b1, 2'h2, 23'h7fffff, 16'hbeef);
        $display("test transfers done");
        ext_req = 4'h1;
        `WAITC(!bbsy_oe)
        `CHK("drv_off", 1'b0, drv_en)
        `WAITC(!bg_in_n[0])
        `CHK("pass_other", 4'he, bg_out_n)
        ext_req = 4'h4;
        `WAITC(bg_in_n == 4'hb)
        tick(4);
        `CHK("pass_own", 4'ha, {bg_out_n[3:1], br_oe[2]})
        ext_req = 4'h0;
        `WAITC(bg_out_n == 4'hf)
        $display("test release and pass done");
        bclr_irq_en = 1;
        set_bit(1'b1);
        `WAITC(backplane_available_flag)
        ext_req = 4'h8;
        clr_req = 1;
        set_bit(1'b1);
        tick(30);
        `CHK("held", 2'h3, {backplane_available_flag, bclr_irq})
        set_bit(1'b0);
        `WAITC(!bbsy_oe)
        clr_req = 0;
        $display("test block transfer done");
        timeout_en = 1;
        {cpu_offboard, cpu_iack} = 2'h1;
        cpu_req = 1;
        `WAITC(cpu_abort)
        `CHK("to_len", 1'b1, guard >= 40 && guard <= 44)
        `CHK("abort_wait", 1'b0, cpu_wait)
        cpu_req = 0;
        tick(3);
        `CHK("br_kept", 4'h4, br_oe)
        ext_req = 4'h0;
        `WAITC(bbsy_oe)
        $display("test time-out done");
        finish_test();
    end
endmodule
